// file: csbu_unit.sv
`timescale 1ns/10ps
`include "csbu_cfg.svh"

// Behaviour
// - Compare subtracts registers, updates six flags
// - Compare with carry also subtracts carry
// - Compare immediate subtracts constant, no writeback
// - Register bit clear skips by 2/3
// - Register bit set skips by 2/3
// - I/O bit clear skips by 2/3
// - I/O bit set skips by 2/3
// - Flag set branch: PC plus k plus 1
// - Flag cleared branch: PC plus k plus 1
// - Equal branches when zero flag set
// - Not equal branches when zero clear
// - Carry set branches when carry set
// - Carry cleared branches when carry clear
// - Same-or-higher on carry clear, lower on set
// - Minus branches when negative flag set
// - Plus branches when negative flag clear
// - Skips and branches keep all flags
module csbu_unit #(
  parameter int PC_WIDTH   = 16,
  parameter int DISP_WIDTH = 7
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Instruction from the decoder, one per cycle while valid
  input  wire logic                  instr_valid,
  input  wire csbu_pkg::csbu_op_e    instr_op,
  input  wire logic [7:0]            first_operand,
  input  wire logic [7:0]            second_operand,
  input  wire logic [7:0]            immediate,
  input  wire logic [7:0]            io_value,
  input  wire logic [2:0]            bit_select,
  input  wire logic [DISP_WIDTH-1:0] displacement,
  input  wire logic                  next_is_long,
  // State
  output logic [PC_WIDTH-1:0]        program_counter,
  output logic [7:0]                 processor_flags_register,
  output logic                       skip_taken,
  output logic                       branch_taken
);

  initial begin
    if (PC_WIDTH < 8 || PC_WIDTH > 16) $error("PC_WIDTH must be 8 to 16");
    if (DISP_WIDTH < 2 || DISP_WIDTH >= PC_WIDTH) $error("DISP_WIDTH out of range");
  end

  // ----------------------------------------------------------------------------
  // Shared subtractor
  // ----------------------------------------------------------------------------
  logic [7:0] sub_rhs;
  logic       sub_borrow;
  logic       f_c, f_z, f_n, f_v, f_s, f_h, d_zero;

  // Immediate form swaps the right operand; carry only for the carry form
  always_comb begin
    sub_rhs    = (instr_op == csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE) ? immediate : second_operand;
    sub_borrow = (instr_op == csbu_pkg::CSBU_OP_COMPARE_CARRY) &
                 processor_flags_register[`CSBU_FLAG_C];
  end

  csbu_sub #(
    .WIDTH (8)
  ) u_sub (
    .minuend    (first_operand),
    .subtrahend (sub_rhs),
    .borrow_in  (sub_borrow),
    .flag_c     (f_c),
    .flag_z     (f_z),
    .flag_n     (f_n),
    .flag_v     (f_v),
    .flag_s     (f_s),
    .flag_h     (f_h),
    .diff_zero  (d_zero)
  );

  // ----------------------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------------------
  logic                cond;
  logic                is_skip;
  logic                is_branch;
  logic                is_compare;
  logic                reg_bit;
  logic                io_bit;
  logic [7:0]          fl;
  logic [PC_WIDTH-1:0] disp_ext;

  always_comb begin
    fl         = processor_flags_register;
    reg_bit    = second_operand[bit_select];
    io_bit     = io_value[bit_select];
    cond       = 1'b0;
    is_skip    = 1'b0;
    is_branch  = 1'b0;
    is_compare = 1'b0;
    // Sign extension lets a branch reach backwards as well as forwards
    disp_ext   = {{(PC_WIDTH-DISP_WIDTH){displacement[DISP_WIDTH-1]}}, displacement};
    unique case (instr_op)
      csbu_pkg::CSBU_OP_COMPARE,
      csbu_pkg::CSBU_OP_COMPARE_CARRY,
      csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE: begin
        is_compare = 1'b1;
      end
      csbu_pkg::CSBU_OP_SKIP_REG_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond    = ~reg_bit;
      end
      csbu_pkg::CSBU_OP_SKIP_REG_BIT_SET: begin
        is_skip = 1'b1;
        cond    = reg_bit;
      end
      csbu_pkg::CSBU_OP_SKIP_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond    = ~io_bit;
      end
      csbu_pkg::CSBU_OP_SKIP_IO_BIT_SET: begin
        is_skip = 1'b1;
        cond    = io_bit;
      end
      csbu_pkg::CSBU_OP_BRANCH_FLAG_SET: begin
        is_branch = 1'b1;
        cond      = fl[bit_select];
      end
      csbu_pkg::CSBU_OP_BRANCH_FLAG_CLEARED: begin
        is_branch = 1'b1;
        cond      = ~fl[bit_select];
      end
      csbu_pkg::CSBU_OP_BRANCH_EQUAL: begin
        is_branch = 1'b1;
        cond      = fl[`CSBU_FLAG_Z];
      end
      csbu_pkg::CSBU_OP_BRANCH_NOT_EQUAL: begin
        is_branch = 1'b1;
        cond      = ~fl[`CSBU_FLAG_Z];
      end
      csbu_pkg::CSBU_OP_BRANCH_CARRY_SET: begin
        is_branch = 1'b1;
        cond      = fl[`CSBU_FLAG_C];
      end
      csbu_pkg::CSBU_OP_BRANCH_CARRY_CLEARED: begin
        is_branch = 1'b1;
        cond      = ~fl[`CSBU_FLAG_C];
      end
      csbu_pkg::CSBU_OP_BRANCH_SAME_OR_HIGHER: begin
        is_branch = 1'b1;
        cond      = ~fl[`CSBU_FLAG_C];
      end
      csbu_pkg::CSBU_OP_BRANCH_LOWER: begin
        is_branch = 1'b1;
        cond      = fl[`CSBU_FLAG_C];
      end
      csbu_pkg::CSBU_OP_BRANCH_MINUS: begin
        is_branch = 1'b1;
        cond      = fl[`CSBU_FLAG_N];
      end
      csbu_pkg::CSBU_OP_BRANCH_PLUS: begin
        is_branch = 1'b1;
        cond      = ~fl[`CSBU_FLAG_N];
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  logic [PC_WIDTH-1:0] next_program_counter;
  logic [7:0]          next_processor_flags_register;
  logic                next_skip_taken;
  logic                next_branch_taken;

  // Flags move only on compares; skips and branches leave them alone
  always_comb begin
    next_program_counter          = program_counter;
    next_processor_flags_register = processor_flags_register;
    next_skip_taken               = 1'b0;
    next_branch_taken             = 1'b0;
    if (instr_valid) begin
      next_program_counter = program_counter + PC_WIDTH'(`CSBU_STEP_ONE);
      if (is_compare) begin
        next_processor_flags_register[`CSBU_FLAG_C] = f_c;
        next_processor_flags_register[`CSBU_FLAG_N] = f_n;
        next_processor_flags_register[`CSBU_FLAG_V] = f_v;
        next_processor_flags_register[`CSBU_FLAG_S] = f_s;
        next_processor_flags_register[`CSBU_FLAG_H] = f_h;
        // The carry form only clears Z so multi-byte compares chain
        if (instr_op == csbu_pkg::CSBU_OP_COMPARE_CARRY) begin
          next_processor_flags_register[`CSBU_FLAG_Z] = d_zero & fl[`CSBU_FLAG_Z];
        end else begin
          next_processor_flags_register[`CSBU_FLAG_Z] = f_z;
        end
      end else if (is_skip && cond) begin
        next_skip_taken      = 1'b1;
        next_program_counter = program_counter + (next_is_long ?
                               PC_WIDTH'(`CSBU_SKIP_LONG) : PC_WIDTH'(`CSBU_SKIP_SHORT));
      end else if (is_branch && cond) begin
        next_branch_taken    = 1'b1;
        next_program_counter = program_counter + disp_ext + PC_WIDTH'(`CSBU_STEP_ONE);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      program_counter          <= PC_WIDTH'(`CSBU_PC_RESET);
      processor_flags_register <= `CSBU_FLAGS_RESET;
      skip_taken               <= 1'b0;
      branch_taken             <= 1'b0;
    end else begin
      program_counter          <= next_program_counter;
      processor_flags_register <= next_processor_flags_register;
      skip_taken               <= next_skip_taken;
      branch_taken             <= next_branch_taken;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence branch_req_s;
    instr_valid && is_branch && cond;
  endsequence

  sequence skip_req_s;
    instr_valid && is_skip && cond;
  endsequence

  branch_target_a: assert property (branch_req_s |=>
      program_counter == $past(program_counter) + $past(disp_ext) + PC_WIDTH'(1))
    else $error("branch target wrong");
  skip_step_a: assert property (skip_req_s |=>
      program_counter - $past(program_counter) == ($past(next_is_long) ? PC_WIDTH'(3) : PC_WIDTH'(2)))
    else $error("skip step wrong");
  flags_kept_a: assert property (instr_valid && (is_skip || is_branch) |=> $stable(processor_flags_register))
    else $error("flags changed by skip or branch");
  cmp_carry_a: assert property (instr_valid && instr_op == csbu_pkg::CSBU_OP_COMPARE &&
      first_operand < second_operand |=> processor_flags_register[`CSBU_FLAG_C])
    else $error("compare carry missing");
  cmp_zero_a: assert property (instr_valid && instr_op == csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE &&
      first_operand == immediate |=> processor_flags_register[`CSBU_FLAG_Z])
    else $error("compare immediate zero missing");
  beq_taken_a: assert property (instr_valid && instr_op == csbu_pkg::CSBU_OP_BRANCH_EQUAL |=>
      branch_taken == $past(processor_flags_register[`CSBU_FLAG_Z]))
    else $error("equal branch decision wrong");
  bne_taken_a: assert property (instr_valid && instr_op == csbu_pkg::CSBU_OP_BRANCH_NOT_EQUAL |=>
      branch_taken != $past(processor_flags_register[`CSBU_FLAG_Z]))
    else $error("not equal branch decision wrong");
  fall_through_a: assert property (instr_valid && is_branch && !cond |=>
      program_counter == $past(program_counter) + PC_WIDTH'(1) ##0 !branch_taken)
    else $error("fall through wrong");
  branch_plus_taken_a: assert property (instr_valid && instr_op == csbu_pkg::CSBU_OP_BRANCH_PLUS |=>
      branch_taken != $past(processor_flags_register[`CSBU_FLAG_N]))
    else $error("plus branch decision wrong");

endmodule

// file: csbu_cfg.svh
`ifndef CSBU_CFG_SVH
`define CSBU_CFG_SVH

// ----------------------------------------------------------------------------
// Flag positions in the processor flags register
// ----------------------------------------------------------------------------
`define CSBU_FLAG_C 3'd0
`define CSBU_FLAG_Z 3'd1
`define CSBU_FLAG_N 3'd2
`define CSBU_FLAG_V 3'd3
`define CSBU_FLAG_S 3'd4
`define CSBU_FLAG_H 3'd5

// ----------------------------------------------------------------------------
// Reset values and program counter steps
// ----------------------------------------------------------------------------
`define CSBU_PC_RESET    16'h0000
`define CSBU_FLAGS_RESET 8'h00
`define CSBU_STEP_ONE    16'h0001
`define CSBU_SKIP_SHORT  16'h0002
`define CSBU_SKIP_LONG   16'h0003

`endif

// file: csbu_pkg.sv
package csbu_pkg;

  // Operation codes presented by the decoder
  typedef enum logic [4:0] {
    CSBU_OP_NONE                  = 5'h00,
    CSBU_OP_COMPARE               = 5'h01,
    CSBU_OP_COMPARE_CARRY         = 5'h02,
    CSBU_OP_COMPARE_IMMEDIATE     = 5'h03,
    CSBU_OP_SKIP_REG_BIT_CLEAR    = 5'h04,
    CSBU_OP_SKIP_REG_BIT_SET      = 5'h05,
    CSBU_OP_SKIP_IO_BIT_CLEAR     = 5'h06,
    CSBU_OP_SKIP_IO_BIT_SET       = 5'h07,
    CSBU_OP_BRANCH_FLAG_SET       = 5'h08,
    CSBU_OP_BRANCH_FLAG_CLEARED   = 5'h09,
    CSBU_OP_BRANCH_EQUAL          = 5'h0a,
    CSBU_OP_BRANCH_NOT_EQUAL      = 5'h0b,
    CSBU_OP_BRANCH_CARRY_SET      = 5'h0c,
    CSBU_OP_BRANCH_CARRY_CLEARED  = 5'h0d,
    CSBU_OP_BRANCH_SAME_OR_HIGHER = 5'h0e,
    CSBU_OP_BRANCH_LOWER          = 5'h0f,
    CSBU_OP_BRANCH_MINUS          = 5'h10,
    CSBU_OP_BRANCH_PLUS           = 5'h11
  } csbu_op_e;

endpackage

// file: csbu_sub.sv
`timescale 1ns/10ps
`include "csbu_cfg.svh"

// Subtractor shared by all compares: flags only, difference discarded
module csbu_sub #(
  parameter int WIDTH = 8
) (
  // Operands
  input  wire logic [WIDTH-1:0] minuend,
  input  wire logic [WIDTH-1:0] subtrahend,
  input  wire logic             borrow_in,
  // Flag results
  output logic                  flag_c,
  output logic                  flag_z,
  output logic                  flag_n,
  output logic                  flag_v,
  output logic                  flag_s,
  output logic                  flag_h,
  // Zero of this difference alone, chained by the caller when needed
  output logic                  diff_zero
);

  initial begin
    if (WIDTH < 5) $error("csbu_sub needs at least 5 bits for half carry");
  end

  logic [WIDTH:0] diff;

  // ----------------------------------------------------------------------------
  // Difference and flags
  // ----------------------------------------------------------------------------
  always_comb begin
    diff      = {1'b0, minuend} - {1'b0, subtrahend} - {{WIDTH{1'b0}}, borrow_in};
    flag_c    = diff[WIDTH];
    diff_zero = (diff[WIDTH-1:0] == '0);
    flag_z    = diff_zero;
    flag_n    = diff[WIDTH-1];
    // Overflow when operand signs differ and result sign follows subtrahend
    flag_v    = (minuend[WIDTH-1] & ~subtrahend[WIDTH-1] & ~diff[WIDTH-1]) |
                (~minuend[WIDTH-1] & subtrahend[WIDTH-1] & diff[WIDTH-1]);
    flag_s    = flag_n ^ flag_v;
    flag_h    = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3]) | (diff[3] & ~minuend[3]);
  end

endmodule

// file: tb.sv
`timescale 1ns/10ps

module tb;
  // --------------------------------------------------------------------------
  // Design ports and bench state
  // --------------------------------------------------------------------------
  logic               clk;
  logic               rst_n;
  logic               instr_valid;
  csbu_pkg::csbu_op_e instr_op;
  logic [7:0]         first_operand;
  logic [7:0]         second_operand;
  logic [7:0]         immediate;
  logic [7:0]         io_value;
  logic [2:0]         bit_select;
  logic [6:0]         displacement;
  logic               next_is_long;
  logic [15:0]        program_counter;
  logic [7:0]         processor_flags_register;
  logic               skip_taken;
  logic               branch_taken;
  logic [15:0]        exp_pc;
  logic [7:0]         ef;
  int                 n_mismatch;
  int                 cmp_count;
  int                 cycles;

  csbu_unit csbu_unit_inst (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .instr_valid              (instr_valid),
    .instr_op                 (instr_op),
    .first_operand            (first_operand),
    .second_operand           (second_operand),
    .immediate                (immediate),
    .io_value                 (io_value),
    .bit_select               (bit_select),
    .displacement             (displacement),
    .next_is_long             (next_is_long),
    .program_counter          (program_counter),
    .processor_flags_register (processor_flags_register),
    .skip_taken               (skip_taken),
    .branch_taken             (branch_taken)
  );

  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Subtraction flags worked out bit by bit; bits 6 and 7 are kept
  function automatic logic [7:0] subf(logic [7:0] a, logic [7:0] b, logic ci, logic chain, logic [7:0] old);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] f;
    r = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    f = old;
    f[0] = r[8];
    f[1] = (r[7:0] == 8'h00) & (~chain | old[1]);
    f[2] = r[7];
    f[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[4] = f[2] ^ f[3];
    f[5] = h[4];
    return f;
  endfunction

  // One instruction: driven for one edge, then all four results judged
  task automatic exec(input csbu_pkg::csbu_op_e op, input logic [7:0] a, input logic [7:0] b,
                      input logic [7:0] k, input logic [2:0] bs, input logic [6:0] d, input logic lng);
    logic sk;
    logic tk;
    logic io;
    sk = 1'b0;
    io = (op == csbu_pkg::CSBU_OP_SKIP_IO_BIT_CLEAR) || (op == csbu_pkg::CSBU_OP_SKIP_IO_BIT_SET);
    tk = 1'b0;
    @(posedge clk);
    instr_valid    <= 1'b1;
    instr_op       <= op;
    first_operand  <= a;
    // Opposite values on the two bit sources catch a skip reading the wrong one
    second_operand <= io ? ~b : b;
    immediate      <= k;
    io_value       <= io ? b : ~b;
    bit_select     <= bs;
    displacement   <= d;
    next_is_long   <= lng;
    case (op)
      csbu_pkg::CSBU_OP_COMPARE:               ef = subf(a, b, 1'b0, 1'b0, ef);
      csbu_pkg::CSBU_OP_COMPARE_CARRY:         ef = subf(a, b, ef[0], 1'b1, ef);
      csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE:     ef = subf(a, k, 1'b0, 1'b0, ef);
      csbu_pkg::CSBU_OP_SKIP_REG_BIT_CLEAR,
      csbu_pkg::CSBU_OP_SKIP_IO_BIT_CLEAR:     sk = ~b[bs];
      csbu_pkg::CSBU_OP_SKIP_REG_BIT_SET,
      csbu_pkg::CSBU_OP_SKIP_IO_BIT_SET:       sk = b[bs];
      csbu_pkg::CSBU_OP_BRANCH_FLAG_SET:       tk = ef[bs];
      csbu_pkg::CSBU_OP_BRANCH_FLAG_CLEARED:   tk = ~ef[bs];
      csbu_pkg::CSBU_OP_BRANCH_EQUAL:          tk = ef[1];
      csbu_pkg::CSBU_OP_BRANCH_NOT_EQUAL:      tk = ~ef[1];
      csbu_pkg::CSBU_OP_BRANCH_CARRY_SET,
      csbu_pkg::CSBU_OP_BRANCH_LOWER:          tk = ef[0];
      csbu_pkg::CSBU_OP_BRANCH_CARRY_CLEARED,
      csbu_pkg::CSBU_OP_BRANCH_SAME_OR_HIGHER: tk = ~ef[0];
      csbu_pkg::CSBU_OP_BRANCH_MINUS:          tk = ef[2];
      csbu_pkg::CSBU_OP_BRANCH_PLUS:           tk = ~ef[2];
      default:                                 tk = 1'b0;
    endcase
    // Displacement sign-extended so backward targets wrap correctly
    exp_pc = sk ? exp_pc + (lng ? 16'h0003 : 16'h0002) : tk ? exp_pc + {{9{d[6]}}, d} + 16'h0001 : exp_pc + 16'h0001;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    check(program_counter, exp_pc, "pc");
    check({8'h00, processor_flags_register}, {8'h00, ef}, "flags");
    check({15'h0000, skip_taken}, {15'h0000, sk}, "skip pulse");
    check({15'h0000, branch_taken}, {15'h0000, tk}, "branch pulse");
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_compare();
    exec(csbu_pkg::CSBU_OP_COMPARE, 8'h03, 8'h05, 8'h00, 3'h0, 7'h00, 1'b0);
    exec(csbu_pkg::CSBU_OP_COMPARE, 8'h80, 8'h01, 8'h00, 3'h0, 7'h00, 1'b0);
    exec(csbu_pkg::CSBU_OP_COMPARE, 8'h03, 8'h05, 8'h00, 3'h0, 7'h00, 1'b0);
    exec(csbu_pkg::CSBU_OP_COMPARE_CARRY, 8'h10, 8'h0f, 8'h00, 3'h0, 7'h00, 1'b0);
    exec(csbu_pkg::CSBU_OP_COMPARE, 8'h5a, 8'h5a, 8'h00, 3'h0, 7'h00, 1'b0);
    exec(csbu_pkg::CSBU_OP_COMPARE_CARRY, 8'h10, 8'h10, 8'h00, 3'h0, 7'h00, 1'b0);
    exec(csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE, 8'h20, 8'h01, 8'h21, 3'h0, 7'h00, 1'b0);
    exec(csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE, 8'h21, 8'h00, 8'h21, 3'h0, 7'h00, 1'b0);
  endtask

  // Tested bit opposite to all others, with flags non-zero beforehand
  task automatic t_skip();
    logic [7:0] v;
    for (int i = 4; i <= 7; i++) begin
      for (int s = 0; s < 4; s++) begin
        v = (8'h01 << ((i + s * 3) % 8));
        exec(csbu_pkg::csbu_op_e'(i[4:0]), 8'h00, s[0] ? v : ~v, 8'h00,
             3'((i + s * 3) % 8), 7'h00, s[1]);
      end
    end
  endtask

  // Each branch under two flag states at an extreme displacement, then one small backward minus branch
  task automatic t_branch();
    for (int p = 0; p < 2; p++) begin
      exec(csbu_pkg::CSBU_OP_COMPARE, p ? 8'h03 : 8'h44, p ? 8'h05 : 8'h44, 8'h00, 3'h0, 7'h00, 1'b0);
      for (int i = 8; i <= 17; i++) begin
        // Bit picks give flag set and flag cleared branches both outcomes
        exec(csbu_pkg::csbu_op_e'(i[4:0]), 8'h00, 8'h00, 8'h00, {1'b0, p[0], ~i[0]},
             i[0] ? 7'h40 : 7'h3f, 1'b0);
      end
    end
    exec(csbu_pkg::CSBU_OP_BRANCH_MINUS, 8'h00, 8'h00, 8'h00, 3'h0, 7'h7e, 1'b0);
  endtask

  // Idle cycles with a live compare on the bus must change nothing
  task automatic t_refused();
    exec(csbu_pkg::CSBU_OP_SKIP_REG_BIT_SET, 8'h00, 8'h80, 8'h00, 3'h7, 7'h00, 1'b1);
    @(posedge clk);
    instr_op       <= csbu_pkg::CSBU_OP_COMPARE;
    second_operand <= 8'hff;
    @(posedge clk);
    #1;
    check(program_counter, exp_pc, "pc idle");
    check({8'h00, processor_flags_register}, {8'h00, ef}, "flags idle");
    check({15'h0000, skip_taken}, 16'h0000, "skip pulse width");
    exec(csbu_pkg::CSBU_OP_NONE, 8'h01, 8'h02, 8'h00, 3'h0, 7'h00, 1'b0);
  endtask

  // Reset in mid-run, then one compare to show the unit resumes
  task automatic t_mid_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    exp_pc = 16'h0000;
    ef     = 8'h00;
    check(program_counter, exp_pc, "pc after reset");
    check({8'h00, processor_flags_register}, 16'h0000, "flags after reset");
    exec(csbu_pkg::CSBU_OP_COMPARE, 8'h7f, 8'hff, 8'h00, 3'h0, 7'h00, 1'b0);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and hang guard
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    n_mismatch     = 0;
    cmp_count      = 0;
    cycles         = 0;
    exp_pc         = 16'h0000;
    ef             = 8'h00;
    rst_n          = 1'b0;
    instr_valid    = 1'b0;
    instr_op       = csbu_pkg::CSBU_OP_NONE;
    first_operand  = 8'h00;
    second_operand = 8'h00;
    immediate      = 8'h00;
    io_value       = 8'h00;
    bit_select     = 3'h0;
    displacement   = 7'h00;
    next_is_long   = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_compare();
    t_skip();
    t_branch();
    t_refused();
    t_mid_reset();
    results();
  end
endmodule
